// ### rtl/itm_pkg.sv
// Constants shared by the I2C time-out supervisor
package itm_pkg;
  // Register byte offsets
  localparam logic [7:0] ITM_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ITM_OFS_STATUS = 8'h04;
  // Time-out control register fields
  localparam int         ITM_BIT_EN     = 7;
  localparam int         ITM_BIT_FLAG   = 6;
  localparam int         ITM_SEL_LSB    = 0;
  localparam int         ITM_SEL_W      = 6;
  localparam logic [7:0] ITM_CTRL_RST   = 8'h00;
  // Status register fields
  localparam int         ITM_ST_ACTIVE  = 0;
  localparam int         ITM_ST_BUSY    = 1;
  // Sub clock periods per counter tick
  localparam int         ITM_PRESCALE   = 32;
  localparam int         ITM_PRE_W      = 5;
  // AXI responses
  localparam logic [1:0] ITM_RESP_OKAY  = 2'h0;
  localparam logic [1:0] ITM_RESP_DEC   = 2'h3;
  // Synchroniser reset level
  localparam logic       ITM_SYNC_RST   = 1'h0;
endpackage : itm_pkg

// ### rtl/itm_sync.sv
// Three-stage synchroniser that passes a value once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module itm_sync #(
  parameter int          WIDTH = 1,
  parameter logic [0:0]  RST   = 1'h0
) (
  // Destination clock
  input  wire logic             clk,
  input  wire logic             resetn,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  import itm_pkg::*;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= {WIDTH{RST}};
      s2_q <= {WIDTH{RST}};
      s3_q <= {WIDTH{RST}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit: a one-cycle glitch is never in stages two and three at once, so it is not passed on
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!resetn) begin
          q[i] <= RST;
        end else if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule : itm_sync
`default_nettype wire

// ### rtl/itm_timeout.sv
// I2C slave bus time-out supervisor with AXI4-Lite control registers
// Function
// - Counting starts when a START is followed by a slave address match.
// - Each serial clock falling edge clears the counter while supervising.
// - Time-out when elapsed time exceeds the period before next falling edge.
// - A STOP ends supervision; no time-out afterwards.
// - On overflow: counter stops, enable clears, flag sets.
// - Time-out requests the shared serial interface interrupt.
// - Time-out resets slave engine and second control register only.
// - Flag stays set until software writes zero.
// - Six-bit low field selects one of 64 periods.
// - Tick every 32 sub-clock periods; time-out after select plus one ticks.
// - Direction bit lives in the second control register reset on time-out.
`timescale 1ns/1ps
`default_nettype none
module itm_timeout (
  // Register clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Sub clock domain that runs the time-out counter
  input  wire logic        sub_clk,
  input  wire logic        sub_resetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Bus pins, receive side only
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  // Slave engine handshake
  input  wire logic        address_match,
  output logic             engine_reset,
  output logic             serial_irq_req
);
  import itm_pkg::*;

  // ---------------- Pin sampling and bus conditions ----------------
  logic scl_f;
  logic sda_f;
  logic scl_prev_q;
  logic sda_prev_q;
  logic busy_q;
  logic armed_q;

  itm_sync #(.WIDTH(2), .RST(1'h1)) u_pin_sync (
    .clk    (aclk),
    .resetn (aresetn),
    .d      ({scl_in, sda_in}),
    .q      ({scl_f, sda_f})
  );

  logic start_det;
  logic stop_det;
  logic scl_fall;
  assign start_det = scl_f && scl_prev_q && sda_prev_q && !sda_f;
  assign stop_det  = scl_f && scl_prev_q && !sda_prev_q && sda_f;
  assign scl_fall  = scl_prev_q && !scl_f;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_prev_q <= 1'h1;
      sda_prev_q <= 1'h1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  // ---------------- Control register ----------------
  logic                 en_q;
  logic                 flag_q;
  logic [ITM_SEL_W-1:0] sel_q;
  logic                 tmo_evt;
  logic                 wr_ctrl;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q   <= ITM_CTRL_RST[ITM_BIT_EN];
      flag_q <= ITM_CTRL_RST[ITM_BIT_FLAG];
      sel_q  <= ITM_CTRL_RST[ITM_SEL_LSB +: ITM_SEL_W];
    end else begin
      if (wr_ctrl && wstrb_q[0]) begin
        en_q   <= wdata_q[ITM_BIT_EN];
        flag_q <= wdata_q[ITM_BIT_FLAG];
        sel_q  <= wdata_q[ITM_SEL_LSB +: ITM_SEL_W];
      end
      if (tmo_evt) begin
        en_q   <= 1'h0;
        flag_q <= 1'h1;
      end
    end
  end

  // ---------------- Supervision state in the register domain ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'h0;
    end else if (stop_det || tmo_evt) begin
      busy_q <= 1'h0;
    end else if (start_det) begin
      busy_q <= 1'h1;
    end
  end

  logic arm_now;
  assign arm_now = busy_q && address_match && en_q && !armed_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'h0;
    end else if (stop_det || tmo_evt || !en_q) begin
      armed_q <= 1'h0;
    end else if (arm_now) begin
      armed_q <= 1'h1;
    end
  end

  // Events cross as toggles, levels as levels
  logic arm_tgl_q;
  logic fall_tgl_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_tgl_q  <= 1'h0;
      fall_tgl_q <= 1'h0;
    end else begin
      if (arm_now) begin
        arm_tgl_q <= !arm_tgl_q;
      end
      if (armed_q && scl_fall) begin
        fall_tgl_q <= !fall_tgl_q;
      end
    end
  end

  // ---------------- Sub clock domain counter ----------------
  // The select field is quasi-static: software should change it only while idle
  logic                 arm_tgl_s;
  logic                 fall_tgl_s;
  logic                 run_s;
  logic [ITM_SEL_W-1:0] sel_s;
  logic                 arm_seen_q;
  logic                 fall_seen_q;
  logic                 sub_run_q;
  logic [ITM_PRE_W-1:0] pre_q;
  logic [ITM_SEL_W-1:0] tick_q;
  logic                 tmo_tgl_q;

  itm_sync #(.WIDTH(ITM_SEL_W + 3), .RST(ITM_SYNC_RST)) u_to_sub (
    .clk    (sub_clk),
    .resetn (sub_resetn),
    .d      ({arm_tgl_q, fall_tgl_q, armed_q, sel_q}),
    .q      ({arm_tgl_s, fall_tgl_s, run_s, sel_s})
  );

  logic arm_s_evt;
  logic fall_s_evt;
  logic tick;
  logic expire;
  assign arm_s_evt  = arm_tgl_s != arm_seen_q;
  assign fall_s_evt = fall_tgl_s != fall_seen_q;
  assign tick       = pre_q == ITM_PRE_W'(ITM_PRESCALE - 1);
  assign expire     = sub_run_q && tick && (tick_q == sel_s);

  always_ff @(posedge sub_clk) begin
    if (!sub_resetn) begin
      arm_seen_q  <= 1'h0;
      fall_seen_q <= 1'h0;
    end else begin
      arm_seen_q  <= arm_tgl_s;
      fall_seen_q <= fall_tgl_s;
    end
  end

  always_ff @(posedge sub_clk) begin
    if (!sub_resetn) begin
      sub_run_q <= 1'h0;
    end else if (arm_s_evt) begin
      sub_run_q <= 1'h1;
    end else if (expire || !run_s) begin
      sub_run_q <= 1'h0;
    end
  end

  always_ff @(posedge sub_clk) begin
    if (!sub_resetn) begin
      pre_q  <= '0;
      tick_q <= '0;
    end else if (!sub_run_q || arm_s_evt || fall_s_evt) begin
      pre_q  <= '0;
      tick_q <= '0;
    end else begin
      pre_q <= ITM_PRE_W'(pre_q + 1'h1);
      if (tick) begin
        tick_q <= ITM_SEL_W'(tick_q + 1'h1);
      end
    end
  end

  always_ff @(posedge sub_clk) begin
    if (!sub_resetn) begin
      tmo_tgl_q <= 1'h0;
    end else if (expire && !fall_s_evt) begin
      tmo_tgl_q <= !tmo_tgl_q;
    end
  end

  // ---------------- Time-out back in the register domain ----------------
  logic tmo_tgl_a;
  logic tmo_seen_q;

  itm_sync #(.WIDTH(1), .RST(ITM_SYNC_RST)) u_to_reg (
    .clk    (aclk),
    .resetn (aresetn),
    .d      (tmo_tgl_q),
    .q      (tmo_tgl_a)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmo_seen_q <= 1'h0;
    end else begin
      tmo_seen_q <= tmo_tgl_a;
    end
  end

  // A late expiry after STOP or disable is dropped here
  assign tmo_evt = (tmo_tgl_a != tmo_seen_q) && armed_q && en_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      engine_reset   <= 1'h0;
      serial_irq_req <= 1'h0;
    end else begin
      engine_reset   <= tmo_evt;
      serial_irq_req <= tmo_evt;
    end
  end

  // ---------------- AXI4-Lite write path ----------------
  logic       aw_got_q;
  logic       w_got_q;
  logic [7:0] awaddr_q;

  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign wr_ctrl       = aw_got_q && w_got_q && (awaddr_q == ITM_OFS_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'h0;
      w_got_q  <= 1'h0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (aw_got_q && w_got_q) begin
      aw_got_q <= 1'h0;
      w_got_q  <= 1'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'h1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'h1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= ITM_RESP_OKAY;
    end else if (aw_got_q && w_got_q) begin
      s_axi_bvalid <= 1'h1;
      if (awaddr_q == ITM_OFS_CTRL || awaddr_q == ITM_OFS_STATUS) begin
        s_axi_bresp <= ITM_RESP_OKAY;
      end else begin
        s_axi_bresp <= ITM_RESP_DEC;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  logic [7:0] araddr;
  assign araddr        = {s_axi_araddr[7:2], 2'h0};
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ITM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ITM_RESP_OKAY;
      if (araddr == ITM_OFS_CTRL) begin
        s_axi_rdata[ITM_BIT_EN]                <= en_q;
        s_axi_rdata[ITM_BIT_FLAG]              <= flag_q;
        s_axi_rdata[ITM_SEL_LSB +: ITM_SEL_W] <= sel_q;
      end else if (araddr == ITM_OFS_STATUS) begin
        s_axi_rdata[ITM_ST_ACTIVE] <= armed_q;
        s_axi_rdata[ITM_ST_BUSY]   <= busy_q;
      end else begin
        s_axi_rresp <= ITM_RESP_DEC;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'h0;
    end
  end
endmodule : itm_timeout
`default_nettype wire

// ### verification/itm_timeout_assertions.sv
// Port checker for the I2C time-out supervisor
`timescale 1ns/1ps
`default_nettype none
module itm_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Engine handshake
  input wire logic        engine_reset,
  input wire logic        serial_irq_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_IRQ_WITH_RESET: assert property (serial_irq_req == engine_reset)
    else $error("interrupt and engine reset differ");
  // Enable clears on expiry, so no second request can follow soon
  AST_IRQ_SINGLE: assert property (serial_irq_req |=> !serial_irq_req [*8])
    else $error("time-out request repeated");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule : itm_checker
bind itm_timeout itm_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .engine_reset, .serial_irq_req);
`default_nettype wire

// ### verification/itm_bus_master.sv
// Bus master model driving the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module itm_bus_master (
  // Bus pins, idle high
  output var logic scl,
  output var logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Pins move 2 ns after the call, never on a register clock edge
  task automatic start_cond();
    #2;
    sda = 1'b0;
    #250 scl = 1'b0;
  endtask : start_cond
  // Data moves only while the clock is low, so no stray START or STOP
  task automatic clock_bits(input int n, input time half);
    #2;
    repeat (n) begin
      sda = 1'($urandom);
      #half scl = 1'b1;
      #half scl = 1'b0;
    end
  endtask : clock_bits
  task automatic stop_cond();
    #2;
    sda = 1'b0;
    #250 scl = 1'b1;
    #250 sda = 1'b1;
    #250;
  endtask : stop_cond
endmodule : itm_bus_master
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the I2C time-out supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
  import itm_pkg::*;
  logic        aclk, aresetn, sub_clk, sub_resetn, address_match;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, engine_reset, serial_irq_req;
  wire         scl, sda;
  logic [33:0] exp_q[$];
  int          n_fail, n_checks, irq_cnt, n, s;
  time         irq_t, t0;
  itm_timeout DUT (.aclk, .aresetn, .sub_clk, .sub_resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in(scl), .sda_in(sda),
    .address_match, .engine_reset, .serial_irq_req);
  itm_bus_master u_master (.scl(scl), .sda(sda));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Free-running sub clock, phase unrelated to aclk
  initial begin
    sub_clk = 1'b0;
    #3;
    forever #16 sub_clk = ~sub_clk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat ($urandom % 3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom % 3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // START, address byte and acknowledge, then an optional match from the engine
  task automatic frame(input logic m);
    u_master.start_cond();
    u_master.clock_bits(9, 250);
    @(posedge aclk);
    address_match <= m;
    t0 = $time;
    @(posedge aclk);
    address_match <= 1'b0;
  endtask : frame
  task automatic quiet(input int ns);
    n = irq_cnt;
    repeat (ns / 10) @(posedge aclk);
    chk({2'h0, 32'(irq_cnt - n)}, 34'h0);
  endtask : quiet
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (serial_irq_req === 1'b1) begin
      irq_cnt++;
      irq_t = $time;
    end
  end
  initial begin
    sub_resetn = 1'b0;
    repeat (6) @(posedge sub_clk);
    sub_resetn <= 1'b1;
  end
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
  initial begin
    {aresetn, address_match, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'hD023));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ITM_OFS_CTRL, {24'h0, ITM_CTRL_RST}, ITM_RESP_OKAY);
    axi_wr(8'h10, 32'hFFFFFFFF, ITM_RESP_DEC);
    axi_rd(8'h10, 32'h0, ITM_RESP_DEC);
    repeat (4) begin
      s = $urandom % 128;
      axi_wr(ITM_OFS_CTRL, {24'hFFFFFF, 8'(s)}, ITM_RESP_OKAY);
      axi_rd(ITM_OFS_CTRL, 32'(s), ITM_RESP_OKAY);
    end
    // Expiry for short periods; counting starts at the match
    repeat (2) begin
      s = $urandom % 4;
      axi_wr(ITM_OFS_CTRL, 32'h80 | 32'(s), ITM_RESP_OKAY);
      n = irq_cnt;
      frame(1'b1);
      while (irq_cnt == n) @(posedge aclk);
      @(posedge aclk);
      chk({33'h0, irq_t >= t0 + (s + 1) * 1024 && irq_t <= t0 + (s + 1) * 1024 + 800}, 34'h1);
      quiet(2000);
      axi_rd(ITM_OFS_CTRL, 32'h40 | 32'(s), ITM_RESP_OKAY);
      axi_wr(ITM_OFS_CTRL, 32'h0, ITM_RESP_OKAY);
      axi_rd(ITM_OFS_CTRL, 32'h0, ITM_RESP_OKAY);
      u_master.stop_cond();
    end
    // Clock edges keep restarting the count, then STOP ends supervision
    axi_wr(ITM_OFS_CTRL, 32'h83, ITM_RESP_OKAY);
    frame(1'b1);
    u_master.clock_bits(18, 250);
    u_master.stop_cond();
    quiet(6000);
    axi_rd(ITM_OFS_CTRL, 32'h83, ITM_RESP_OKAY);
    axi_wr(ITM_OFS_CTRL, 32'h0, ITM_RESP_OKAY);
    frame(1'b1);
    quiet(3000);
    u_master.stop_cond();
    axi_wr(ITM_OFS_CTRL, 32'h80, ITM_RESP_OKAY);
    frame(1'b0);
    quiet(3000);
    u_master.stop_cond();
    repeat (5) @(posedge aclk);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
